/* rtl/tuc_pkg.sv */
// package for the triple up counter block
package tuc_pkg;
  localparam logic [3:0] TUC_ADDR_CNT_A   = 4'h5;
  localparam logic [3:0] TUC_ADDR_CNT_BL  = 4'h6;
  localparam logic [3:0] TUC_ADDR_CNT_BH  = 4'h7;
  localparam logic [3:0] TUC_ADDR_A_CTL   = 4'h8;
  localparam logic [3:0] TUC_ADDR_BC_CTL  = 4'h9;
  localparam logic [3:0] TUC_ADDR_IR_CTL  = 4'ha;
  localparam logic [3:0] TUC_ADDR_IRQ     = 4'hf;
  localparam logic [4:0] TUC_PAGE_CTL     = 5'h00;
  localparam logic [4:0] TUC_PAGE_DATA    = 5'h01;
  localparam int         TUC_BIT_A_EN     = 2;
  localparam int         TUC_BIT_BH_EN    = 7;
  localparam int         TUC_BIT_B_EN     = 6;
  localparam int         TUC_BIT_C_EN     = 2;
  localparam int         TUC_BIT_SCALE_EN = 7;
  localparam int         TUC_BIT_SCALE_LO = 4;
  localparam int         TUC_BIT_IR_EN    = 3;
  localparam int         TUC_BIT_CARRIER  = 2;
  localparam int         TUC_BIT_FLAG_A   = 3;
  localparam int         TUC_BIT_FLAG_B   = 4;
  localparam int         TUC_BIT_FLAG_C   = 5;
  localparam logic [7:0] TUC_RST_BYTE     = 8'h00;
  localparam logic [7:0] TUC_A_CTL_MASK   = 8'h04;
  localparam logic [7:0] TUC_BC_CTL_MASK  = 8'hc4;
  localparam logic [7:0] TUC_IRQ_MASK     = 8'h38;
  localparam int         TUC_CLK_HZ       = 25000000;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] page;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tuc_bus_t;
endpackage

/* rtl/tuc_timers.sv */
// three up counters with preload, scaler and interrupt flags
`timescale 1ns/1ns
// Contract
// - counters count up and reload preload on wrap through zero
// - software write loads both live count and preload
// - software read returns live count
// - enabled counter sets its flag in the reload cycle
// - counter a is an 8-bit read-write up counter
// - all counter registers clear on reset
// - counter a times out after 256 minus count ticks
// - counter b low byte is 8-bit read-write up counter
// - high byte enable joins b bytes into one 16-bit counter
// - b without high byte times out after 256 minus low count
// - b with high byte times out after 65536 minus 16-bit count
// - c with carrier select and ir enable holds its preload
// - c is an ordinary up counter otherwise
// - c up mode timeout is scaler times 256 minus count
// - carrier rate is count clock over twice (1 plus c) times scaler
// - ir control holds scaler select and scaler enable
module tuc_timers
  import tuc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_clk_en,
  input  wire logic       i_osc_div2,
  input  wire tuc_bus_t   i_bus,
  output logic [7:0]      o_rdata,
  output logic            o_carrier_tick,
  output logic            o_irq
);
  logic [7:0]  cnt_a_r, pre_a_r, cnt_bl_r, pre_bl_r, cnt_bh_r, pre_bh_r;
  logic [7:0]  cnt_c_r, pre_c_r;
  logic [7:0]  a_ctl_r, bc_ctl_r, ir_ctl_r, mask_r, flag_r;
  logic        tick_r;
  logic [7:0]  scale_cnt_r;
  logic [7:0]  scale_max;
  logic        tick, c_tick, ir_mode;
  logic        wrap_a, wrap_b, wrap_c;
  logic        wr_ctl, wr_dat, rd_ctl, rd_dat;
  logic [15:0] b_full;

  assign wr_ctl = i_bus.wr && (i_bus.page == TUC_PAGE_CTL);
  assign wr_dat = i_bus.wr && (i_bus.page == TUC_PAGE_DATA);
  assign rd_ctl = i_bus.rd && (i_bus.page == TUC_PAGE_CTL);
  assign rd_dat = i_bus.rd && (i_bus.page == TUC_PAGE_DATA);

  // count clock: every sysclk, or every other one when divided by 2
  assign tick = i_clk_en && (!i_osc_div2 || tick_r);
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tick_r <= 1'b0;
    end else if (i_clk_en) begin
      tick_r <= !tick_r;
    end
  end

  // prescaler ratio 2^(sel+1) when enabled, 1 otherwise
  always_comb begin
    scale_max = 8'h00;
    if (ir_ctl_r[TUC_BIT_SCALE_EN]) begin
      scale_max = 8'(( 9'h002 << ir_ctl_r[TUC_BIT_SCALE_LO +: 3]) - 9'h001);
    end
  end
  assign c_tick = tick && (scale_cnt_r == scale_max);
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      scale_cnt_r <= 8'h00;
    end else if (tick && bc_ctl_r[TUC_BIT_C_EN]) begin
      scale_cnt_r <= c_tick ? 8'h00 : scale_cnt_r + 8'h01;
    end
  end

  assign ir_mode = ir_ctl_r[TUC_BIT_CARRIER] && ir_ctl_r[TUC_BIT_IR_EN];
  assign b_full  = {cnt_bh_r, cnt_bl_r};
  assign wrap_a  = tick && a_ctl_r[TUC_BIT_A_EN] && (cnt_a_r == 8'hff);
  assign wrap_b  = tick && bc_ctl_r[TUC_BIT_B_EN] &&
                   (bc_ctl_r[TUC_BIT_BH_EN] ? (b_full == 16'hffff) : (cnt_bl_r == 8'hff));
  assign wrap_c  = c_tick && bc_ctl_r[TUC_BIT_C_EN] && (cnt_c_r == 8'hff);

  // carrier half period: (1 + c) scaled ticks from the held preload
  logic [7:0] carr_cnt_r;
  logic       carr_tick_r;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      carr_cnt_r  <= 8'h00;
      carr_tick_r <= 1'b0;
    end else begin
      carr_tick_r <= 1'b0;
      if (c_tick && ir_mode && bc_ctl_r[TUC_BIT_C_EN]) begin
        if (carr_cnt_r == pre_c_r) begin
          carr_cnt_r  <= 8'h00;
          carr_tick_r <= 1'b1;
        end else begin
          carr_cnt_r <= carr_cnt_r + 8'h01;
        end
      end
    end
  end
  assign o_carrier_tick = carr_tick_r;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_a_r <= TUC_RST_BYTE;
      pre_a_r <= TUC_RST_BYTE;
    end else if (wr_dat && i_bus.addr == TUC_ADDR_CNT_A) begin
      cnt_a_r <= i_bus.wdata;
      pre_a_r <= i_bus.wdata;
    end else if (wrap_a) begin
      cnt_a_r <= pre_a_r;
    end else if (tick && a_ctl_r[TUC_BIT_A_EN]) begin
      cnt_a_r <= cnt_a_r + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_bl_r <= TUC_RST_BYTE;
      pre_bl_r <= TUC_RST_BYTE;
      cnt_bh_r <= TUC_RST_BYTE;
      pre_bh_r <= TUC_RST_BYTE;
    end else begin
      if (wr_dat && i_bus.addr == TUC_ADDR_CNT_BL) begin
        cnt_bl_r <= i_bus.wdata;
        pre_bl_r <= i_bus.wdata;
      end else if (wrap_b) begin
        cnt_bl_r <= pre_bl_r;
      end else if (tick && bc_ctl_r[TUC_BIT_B_EN]) begin
        cnt_bl_r <= cnt_bl_r + 8'h01;
      end
      if (wr_dat && i_bus.addr == TUC_ADDR_CNT_BH) begin
        cnt_bh_r <= i_bus.wdata;
        pre_bh_r <= i_bus.wdata;
      end else if (wrap_b && bc_ctl_r[TUC_BIT_BH_EN]) begin
        cnt_bh_r <= pre_bh_r;
      end else if (tick && bc_ctl_r[TUC_BIT_B_EN] && bc_ctl_r[TUC_BIT_BH_EN] && cnt_bl_r == 8'hff) begin
        cnt_bh_r <= cnt_bh_r + 8'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_c_r <= TUC_RST_BYTE;
      pre_c_r <= TUC_RST_BYTE;
    end else if (wr_dat && i_bus.addr == TUC_ADDR_A_CTL) begin
      cnt_c_r <= i_bus.wdata;
      pre_c_r <= i_bus.wdata;
    end else if (ir_mode) begin
      cnt_c_r <= pre_c_r;
    end else if (wrap_c) begin
      cnt_c_r <= pre_c_r;
    end else if (c_tick && bc_ctl_r[TUC_BIT_C_EN]) begin
      cnt_c_r <= cnt_c_r + 8'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      a_ctl_r  <= TUC_RST_BYTE;
      bc_ctl_r <= TUC_RST_BYTE;
      ir_ctl_r <= TUC_RST_BYTE;
      mask_r   <= TUC_RST_BYTE;
    end else if (wr_ctl) begin
      if (i_bus.addr == TUC_ADDR_A_CTL) begin
        a_ctl_r <= i_bus.wdata & TUC_A_CTL_MASK;
      end else if (i_bus.addr == TUC_ADDR_BC_CTL) begin
        bc_ctl_r <= i_bus.wdata & TUC_BC_CTL_MASK;
      end else if (i_bus.addr == TUC_ADDR_IR_CTL) begin
        ir_ctl_r <= i_bus.wdata;
      end else if (i_bus.addr == TUC_ADDR_IRQ) begin
        mask_r <= i_bus.wdata & TUC_IRQ_MASK;
      end
    end
  end

  // flags: set wins over a software clear in the same cycle
  logic [7:0] flag_set;
  logic [7:0] flag_keep;
  always_comb begin
    flag_set = 8'h00;
    flag_set[TUC_BIT_FLAG_A] = wrap_a;
    flag_set[TUC_BIT_FLAG_B] = wrap_b;
    flag_set[TUC_BIT_FLAG_C] = wrap_c;
    flag_keep = flag_r;
    if (wr_dat && i_bus.addr == TUC_ADDR_IRQ) begin
      flag_keep = flag_r & i_bus.wdata;
    end
    if (rd_dat && i_bus.addr == TUC_ADDR_IRQ) begin
      flag_keep = 8'h00;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      flag_r <= TUC_RST_BYTE;
    end else begin
      flag_r <= (flag_keep | flag_set) & TUC_IRQ_MASK;
    end
  end
  assign o_irq = |(flag_r & mask_r);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (rd_ctl) begin
      if (i_bus.addr == TUC_ADDR_A_CTL) begin
        o_rdata <= a_ctl_r;
      end else if (i_bus.addr == TUC_ADDR_BC_CTL) begin
        o_rdata <= bc_ctl_r;
      end else if (i_bus.addr == TUC_ADDR_IR_CTL) begin
        o_rdata <= ir_ctl_r;
      end else if (i_bus.addr == TUC_ADDR_IRQ) begin
        o_rdata <= mask_r;
      end else begin
        o_rdata <= 8'h00;
      end
    end else if (rd_dat) begin
      if (i_bus.addr == TUC_ADDR_CNT_A) begin
        o_rdata <= cnt_a_r;
      end else if (i_bus.addr == TUC_ADDR_CNT_BL) begin
        o_rdata <= cnt_bl_r;
      end else if (i_bus.addr == TUC_ADDR_CNT_BH) begin
        o_rdata <= cnt_bh_r;
      end else if (i_bus.addr == TUC_ADDR_A_CTL) begin
        o_rdata <= cnt_c_r;
      end else if (i_bus.addr == TUC_ADDR_IRQ) begin
        o_rdata <= flag_r;
      end else begin
        o_rdata <= 8'h00;
      end
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

/* sim/tuc_timers_chk.sv */
// port checker for the triple up counter block
`timescale 1ns/1ns
module tuc_timers_chk
  import tuc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_clk_en,
  input  wire tuc_bus_t   i_bus,
  input  wire logic [7:0] o_rdata,
  input  wire logic       o_carrier_tick,
  input  wire logic       o_irq
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic       mwr, lw_v_r, quiet_r, ir_off_r;
  logic [3:0] lw_a_r;
  logic [7:0] lw_d_r, ir_r;
  assign mwr = i_bus.wr && i_bus.page == TUC_PAGE_CTL && i_bus.addr == TUC_ADDR_IRQ;
  always_ff @(posedge i_core_clk) begin
    quiet_r  <= !i_clk_en && !mwr;
    ir_off_r <= i_sys_rst || !(ir_r[TUC_BIT_IR_EN] && ir_r[TUC_BIT_CARRIER]);
    if (i_sys_rst) begin
      lw_v_r <= 1'b0;
      ir_r   <= 8'h00;
    end else if (i_bus.wr) begin
      // remembered value stays valid only while counting is frozen
      lw_v_r <= i_bus.page == TUC_PAGE_DATA && i_bus.addr inside {[4'h5:4'h8]};
      lw_a_r <= i_bus.addr;
      lw_d_r <= i_bus.wdata;
      if (i_bus.page == TUC_PAGE_CTL && i_bus.addr == TUC_ADDR_IR_CTL) ir_r <= i_bus.wdata;
    end else if (i_clk_en) lw_v_r <= 1'b0;
  end
  AST_RD_IDLE: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("data outside slot");
  AST_RST_CLR: assert property (disable iff (1'b0) i_sys_rst |=>
    o_rdata == 8'h00 && !o_irq && !o_carrier_tick) else $error("reset left outputs");
  AST_RD_WR: assert property (i_bus.rd && i_bus.page == TUC_PAGE_DATA && i_bus.addr == lw_a_r
    && lw_v_r && !i_clk_en |=> o_rdata == lw_d_r) else $error("read differs from write");
  AST_UNMAPPED: assert property (i_bus.rd && i_bus.addr == 4'h0 |=> o_rdata == 8'h00) else $error("unmapped read");
  AST_MASK_OFF: assert property (mwr && i_bus.wdata == 8'h00 |=> !o_irq) else $error("irq with mask 0");
  AST_IRQ_HOLD: assert property (o_irq && !i_bus.wr && !(i_bus.rd && i_bus.page == TUC_PAGE_DATA
    && i_bus.addr == TUC_ADDR_IRQ) |=> o_irq) else $error("irq dropped");
  AST_FROZEN: assert property (quiet_r && !i_clk_en && !mwr && !o_irq |=> !o_irq) else $error("frozen irq");
  AST_CARRIER_OFF: assert property (ir_off_r && !(ir_r[TUC_BIT_IR_EN] && ir_r[TUC_BIT_CARRIER])
    |-> !o_carrier_tick) else $error("carrier outside ir mode");
endmodule

/* sim/tuc_timers_tb.sv */
// self-checking testbench for the triple up counter block
`timescale 1ns/1ns
module tuc_timers_tb
  import tuc_pkg::*;
();
  logic       i_core_clk = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b0, i_osc_div2 = 1'b0;
  tuc_bus_t   bus = '0;
  logic [7:0] o_rdata, q;
  logic       o_carrier_tick, o_irq;
  int         n_mismatch = 0, num_checks = 0, cyc = 0;
  tuc_timers tuc_timers_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_osc_div2(i_osc_div2), .i_bus(bus), .o_rdata(o_rdata), .o_carrier_tick(o_carrier_tick), .o_irq(o_irq));
  always #20 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      results;
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one strobe cycle then an idle cycle, read data caught in between
  task automatic acc(input logic w, input logic [4:0] pg, input logic [3:0] ad, input logic [7:0] d);
    bus <= '{wr: w, rd: !w, page: pg, addr: ad, wdata: d};
    @(posedge i_core_clk);
    bus <= '0;
    #1 q = o_rdata;
    @(posedge i_core_clk);
  endtask
  task automatic rd(input logic [4:0] pg, input logic [3:0] ad, input logic [7:0] exp);
    acc(1'b0, pg, ad, 8'h00);
    chk({8'h00, q}, {8'h00, exp});
  endtask
  // irq is waited low first, since a read clears it a cycle late at most
  task automatic wsig(input bit s, output int t);
    #1;
    while (o_irq === 1'b1 && !s) begin
      @(posedge i_core_clk);
      #1;
    end
    while ((s ? o_carrier_tick : o_irq) !== 1'b1) begin
      @(posedge i_core_clk);
      #1;
    end
    t = cyc;
    @(posedge i_core_clk);
  endtask
  task automatic tmr(input logic [3:0] ca, input logic [7:0] cv, input logic [3:0] da,
                     input logic [7:0] pl, input logic [7:0] fl, input int per);
    int t1, t2;
    acc(1'b1, 5'h01, da, pl);
    acc(1'b1, 5'h00, TUC_ADDR_IRQ, fl);
    acc(1'b1, 5'h00, ca, cv);
    wsig(1'b0, t1);
    rd(5'h01, TUC_ADDR_IRQ, fl);
    wsig(1'b0, t2);
    chk(16'(t2 - t1), 16'(per));
    acc(1'b1, 5'h00, ca, 8'h00);
    acc(1'b1, 5'h00, TUC_ADDR_IRQ, 8'h00);
    acc(1'b1, 5'h01, TUC_ADDR_IRQ, 8'h00);
    rd(5'h01, TUC_ADDR_IRQ, 8'h00);
  endtask
  // first tick after a mode change may be short, so one is skipped
  task automatic car(input int n);
    int t1, t2;
    wsig(1'b1, t1);
    wsig(1'b1, t1);
    wsig(1'b1, t2);
    chk(16'(t2 - t1), 16'(n));
  endtask
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 32; k++) rd(5'(k / 16), 4'(k), 8'h00);
    acc(1'b1, 5'h01, TUC_ADDR_CNT_A, 8'hf0);
    rd(5'h01, TUC_ADDR_CNT_A, 8'hf0);
    acc(1'b1, 5'h00, TUC_ADDR_A_CTL, 8'hff);
    rd(5'h00, TUC_ADDR_A_CTL, 8'h04);
    i_clk_en <= 1'b1;
    tmr(TUC_ADDR_A_CTL, 8'h04, TUC_ADDR_CNT_A, 8'hf0, 8'h08, 16);
    i_osc_div2 <= 1'b1;
    tmr(TUC_ADDR_A_CTL, 8'h04, TUC_ADDR_CNT_A, 8'hf0, 8'h08, 32);
    i_osc_div2 <= 1'b0;
    acc(1'b1, 5'h01, TUC_ADDR_CNT_BH, 8'hfe);
    tmr(TUC_ADDR_BC_CTL, 8'h40, TUC_ADDR_CNT_BL, 8'hf0, 8'h10, 16);
    tmr(TUC_ADDR_BC_CTL, 8'hc0, TUC_ADDR_CNT_BL, 8'hf0, 8'h10, 272);
    acc(1'b1, 5'h00, TUC_ADDR_IR_CTL, 8'h90);
    tmr(TUC_ADDR_BC_CTL, 8'h04, 4'h8, 8'hf8, 8'h20, 32);
    acc(1'b1, 5'h01, 4'h8, 8'h03);
    acc(1'b1, 5'h00, TUC_ADDR_BC_CTL, 8'h04);
    acc(1'b1, 5'h00, TUC_ADDR_IR_CTL, 8'h0c);
    car(4);
    rd(5'h01, 4'h8, 8'h03);
    acc(1'b1, 5'h00, TUC_ADDR_IR_CTL, 8'h8c);
    car(8);
    i_osc_div2 <= 1'b1;
    car(16);
    results;
  end
endmodule
bind tuc_timers tuc_timers_chk tuc_timers_chk_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_clk_en(i_clk_en), .i_bus(i_bus), .o_rdata(o_rdata), .o_carrier_tick(o_carrier_tick), .o_irq(o_irq));
